// >>> hdl/ipc_top.sv
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module ipc_top
    import ipc_pkg::*;
#(
    parameter int NP = NPTS
) (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // field inputs and time base
    input wire logic [NP-1:0] pin_in,
    input wire logic [63:0] time_now,
    // axi4-lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // interrupt
    output logic irq
);
    // ==================================================
    // storage
    logic [NP-1:0] sync1;
    logic [NP-1:0] sync2;
    logic [NP-1:0] sync3;
    logic [NP-1:0] raw_ok;
    logic [7:0] pre_cnt;
    logic [9:0] us_cnt;
    logic us_tick;
    logic ms_tick;
    logic [15:0] dly_on [NP];
    logic [15:0] dly_off [NP];
    logic [31:0] cfg [NP];
    logic [31:0] irq_stat;
    logic [31:0] irq_mask;
    logic [11:0] aw_addr;
    logic aw_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_full;
    logic [NP-1:0] st_vec;
    logic [NP-1:0] ts_ev_vec;
    logic [NP-1:0] ch_ev_vec;
    logic [63:0] ts_vec [NP];

    // ==================================================
    // field input synchroniser
    // a change is taken only when stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else if (ce) begin
            sync1 <= pin_in;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            raw_ok <= '0;
        end else if (ce) begin
            raw_ok <= (sync2 & sync3) | (raw_ok & (sync2 ^ sync3));
        end
    end

    // ==================================================
    // microsecond and millisecond ticks for filters and windows
    wire pre_end = pre_cnt == 8'(CYC_PER_US - 1);
    wire us_end = us_cnt == 10'(US_PER_MS - 1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_cnt <= 8'h00;
            us_tick <= 1'b0;
        end else if (ce) begin
            pre_cnt <= pre_end ? 8'h00 : pre_cnt + 8'd1;
            us_tick <= pre_end;
        end
    end

    // registered ticks reach every point on one edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            us_cnt <= 10'h000;
            ms_tick <= 1'b0;
        end else if (ce) begin
            ms_tick <= pre_end && us_end;
            if (pre_end) begin
                us_cnt <= us_end ? 10'h000 : us_cnt + 10'd1;
            end
        end
    end

    // ==================================================
    // points
    for (genvar i = 0; i < NP; i++) begin : g_pt
        ipc_pt_if pif ();
        assign pif.dly_on = dly_on[i];
        assign pif.dly_off = dly_off[i];
        assign pif.cap_on = cfg[i][F_CAP_ON];
        assign pif.cap_off = cfg[i][F_CAP_OFF];
        assign pif.latch = cfg[i][F_LATCH];
        assign pif.ts_held = irq_stat[IRQ_TS_LO + i];
        assign pif.chat_en = cfg[i][F_CHAT_EN];
        assign pif.chat_cnt = cfg[i][F_CNT_LO +: 7];
        assign pif.chat_ms = cfg[i][F_MS_LO +: 10];
        assign pif.raw = raw_ok[i];
        assign st_vec[i] = pif.state;
        assign ts_ev_vec[i] = pif.ts_evt;
        assign ch_ev_vec[i] = pif.chat_evt;
        assign ts_vec[i] = pif.ts;
        ipc_point u_pt (
            .aclk(aclk),
            .aresetn(aresetn),
            .ce(ce),
            .us_tick(us_tick),
            .ms_tick(ms_tick),
            .now(time_now),
            .p(pif.pt)
        );
    end

    // ==================================================
    // write channel: address and data taken in either order
    // readies drop with ce, or a beat would be lost while frozen
    assign s_axi_awready = ce && !aw_full && !s_axi_bvalid;
    assign s_axi_wready = ce && !w_full && !s_axi_bvalid;
    wire do_wr = aw_full && w_full && !s_axi_bvalid;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    wire w_pt = aw_addr[11:9] == A_PT_BASE[11:9];
    wire [3:0] w_idx = aw_addr[PT_STRIDE_LOG2 +: 4];
    wire [4:0] w_off = aw_addr[4:0];
    wire w_on = w_pt && (w_off == O_DLY_ON);
    wire w_off_d = w_pt && (w_off == O_DLY_OFF);
    wire w_cfg = w_pt && (w_off == O_CFG);
    wire w_ro = w_pt && (w_off == O_TS_LO || w_off == O_TS_HI);
    wire w_stat = aw_addr == A_IRQ_STAT;
    wire w_mask = aw_addr == A_IRQ_MASK;
    wire w_ok = w_on || w_off_d || w_cfg || w_ro || w_stat || w_mask
             || aw_addr == A_STATE || aw_addr == A_TBASE;
    wire [31:0] on_new = merge({16'h0, dly_on[w_idx]}, w_data, w_strb);
    wire [31:0] off_new = merge({16'h0, dly_off[w_idx]}, w_data, w_strb);
    wire [31:0] clr_bits = (do_wr && w_stat)
                         ? merge(32'h0, w_data, w_strb) : 32'h0;
    wire [31:0] set_bits = {ts_ev_vec, ch_ev_vec};
    // events win over a clear arriving in the same cycle
    wire [31:0] next_stat = (irq_stat & ~clr_bits) | set_bits;

    // address beat held until the write is performed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            aw_addr <= 12'h000;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full <= 1'b1;
                aw_addr <= {s_axi_awaddr[11:2], 2'b00};
            end else if (do_wr) begin
                aw_full <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_wr) begin
                w_full <= 1'b0;
            end
        end
    end

    // response stands until bready is sampled high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (ce) begin
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= w_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==================================================
    // interrupt status and mask
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat <= 32'h0;
        end else if (ce) begin
            irq_stat <= next_stat;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask <= 32'h0;
        end else if (ce && do_wr && w_mask) begin
            irq_mask <= merge(irq_mask, w_data, w_strb);
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // ==================================================
    // filter delays; values above 50 ms are clamped inside the point
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int k = 0; k < NP; k++) begin
                dly_on[k] <= DLY_RST;
            end
        end else if (ce && do_wr && w_on) begin
            dly_on[w_idx] <= on_new[15:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int k = 0; k < NP; k++) begin
                dly_off[k] <= DLY_RST;
            end
        end else if (ce && do_wr && w_off_d) begin
            dly_off[w_idx] <= off_new[15:0];
        end
    end

    // ==================================================
    // point configuration, unused bits forced to zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int k = 0; k < NP; k++) begin
                cfg[k] <= {6'h00, CHAT_MS_RST, 1'b0, CHAT_CNT_RST, 8'h00};
            end
        end else if (ce && do_wr && w_cfg) begin
            cfg[w_idx] <= merge(cfg[w_idx], w_data, w_strb)
                        & {6'h00, 10'h3ff, 1'b0, 7'h7f, 8'h0f};
        end
    end

    // ==================================================
    // read channel: one cycle from address to data
    assign s_axi_arready = ce && !s_axi_rvalid;
    wire [11:0] r_addr = {s_axi_araddr[11:2], 2'b00};
    wire r_pt = r_addr[11:9] == A_PT_BASE[11:9];
    wire [3:0] r_idx = r_addr[PT_STRIDE_LOG2 +: 4];
    wire [4:0] r_off = r_addr[4:0];
    wire [63:0] r_ts = ts_vec[r_idx];
    wire [31:0] r_pt_data =
        (r_off == O_DLY_ON) ? {16'h0, dly_on[r_idx]} :
        (r_off == O_DLY_OFF) ? {16'h0, dly_off[r_idx]} :
        (r_off == O_CFG) ? cfg[r_idx] :
        (r_off == O_TS_LO) ? r_ts[31:0] : r_ts[63:32];
    wire r_pt_ok = r_pt && (r_off == O_DLY_ON || r_off == O_DLY_OFF
                 || r_off == O_CFG || r_off == O_TS_LO
                 || r_off == O_TS_HI);
    wire [31:0] r_state = {16'h0, st_vec} | {raw_ok, 16'h0};
    wire r_gl_ok = r_addr == A_STATE || r_addr == A_IRQ_STAT
                || r_addr == A_IRQ_MASK || r_addr == A_TBASE;
    wire [31:0] r_gl_data =
        (r_addr == A_STATE) ? r_state :
        (r_addr == A_IRQ_STAT) ? irq_stat :
        (r_addr == A_IRQ_MASK) ? irq_mask : time_now[31:0];
    wire [31:0] next_rdata = r_pt_ok ? r_pt_data
                           : r_gl_ok ? r_gl_data : 32'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= (r_pt_ok || r_gl_ok) ? RESP_OKAY
                                                    : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> hdl/ipc_pkg.sv
package ipc_pkg;
    // ==================================================
    // geometry and timing
    localparam int NPTS = 16;
    localparam int CLK_HZ = 100_000_000;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int US_PER_MS = 1000;
    localparam logic [15:0] FILT_MAX_US = 16'd50000;
    localparam logic [6:0] CHAT_CNT_MIN = 7'd2;
    localparam logic [9:0] CHAT_MS_MIN = 10'd1;
    localparam logic [9:0] CHAT_MS_MAX = 10'd1000;
    // ==================================================
    // register map (byte addresses)
    localparam logic [11:0] A_STATE = 12'h000;
    localparam logic [11:0] A_IRQ_STAT = 12'h004;
    localparam logic [11:0] A_IRQ_MASK = 12'h008;
    localparam logic [11:0] A_TBASE = 12'h00c;
    localparam logic [11:0] A_PT_BASE = 12'h200;
    localparam int PT_STRIDE_LOG2 = 5;
    localparam logic [4:0] O_DLY_ON = 5'h00;
    localparam logic [4:0] O_DLY_OFF = 5'h04;
    localparam logic [4:0] O_CFG = 5'h08;
    localparam logic [4:0] O_TS_LO = 5'h0c;
    localparam logic [4:0] O_TS_HI = 5'h10;
    // ==================================================
    // point config field layout and reset values
    localparam int F_CAP_ON = 0;
    localparam int F_CAP_OFF = 1;
    localparam int F_LATCH = 2;
    localparam int F_CHAT_EN = 3;
    localparam int F_CNT_LO = 8;
    localparam int F_MS_LO = 16;
    localparam logic [15:0] DLY_RST = 16'h0000;
    localparam logic [6:0] CHAT_CNT_RST = 7'h02;
    localparam logic [9:0] CHAT_MS_RST = 10'h001;
    localparam int IRQ_TS_LO = 16;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// >>> hdl/ipc_pt_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ipc_pt_if;
    // config, held flag and synchronised input from the controller side
    logic [15:0] dly_on;
    logic [15:0] dly_off;
    logic cap_on;
    logic cap_off;
    logic latch;
    logic ts_held;
    logic chat_en;
    logic [6:0] chat_cnt;
    logic [9:0] chat_ms;
    logic raw;
    // results from the point
    logic state;
    logic [63:0] ts;
    logic ts_evt;
    logic chat_evt;
    modport ctl (
        output dly_on, dly_off, cap_on, cap_off, latch, ts_held,
        output chat_en, chat_cnt, chat_ms, raw,
        input state, ts, ts_evt, chat_evt
    );
    modport pt (
        input dly_on, dly_off, cap_on, cap_off, latch, ts_held,
        input chat_en, chat_cnt, chat_ms, raw,
        output state, ts, ts_evt, chat_evt
    );
endinterface
`default_nettype wire

// >>> hdl/ipc_point.sv
`timescale 1ns/10ps
`default_nettype none
module ipc_point
    import ipc_pkg::*;
(
    // clocking
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // shared time base
    input wire logic us_tick,
    input wire logic ms_tick,
    input wire logic [63:0] now,
    // point
    ipc_pt_if.pt p
);
    logic [15:0] cnt_us;
    logic diff_q;
    logic [63:0] t_edge;
    logic [9:0] ms_cnt;
    logic [6:0] tr_cnt;

    // ==================================================
    // filter decode
    wire diff = p.raw != p.state;
    wire [15:0] dly_raw = p.state ? p.dly_off : p.dly_on;
    wire [15:0] target = (dly_raw > FILT_MAX_US) ? FILT_MAX_US : dly_raw;
    wire accept = diff && (cnt_us >= target);
    wire rising = !p.state;
    wire want_ts = rising ? p.cap_on : p.cap_off;
    wire do_ts = accept && want_ts && !(p.latch && p.ts_held);
    wire [6:0] cnt_lim = (p.chat_cnt < CHAT_CNT_MIN) ? CHAT_CNT_MIN
                                                      : p.chat_cnt;
    wire [9:0] ms_lim = (p.chat_ms < CHAT_MS_MIN) ? CHAT_MS_MIN
                      : (p.chat_ms > CHAT_MS_MAX) ? CHAT_MS_MAX : p.chat_ms;
    wire win_end = ms_tick && (ms_cnt + 10'd1 >= ms_lim);
    wire [6:0] tr_base = win_end ? 7'd0 : tr_cnt;
    wire chat_hit = accept && (tr_base + 7'd1 >= cnt_lim);

    // ==================================================
    // filter: a reversal drops the pending count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_us <= 16'h0000;
            diff_q <= 1'b0;
            t_edge <= 64'h0;
            p.state <= 1'b0;
        end else if (ce) begin
            diff_q <= diff && !accept;
            if (diff && !diff_q) begin
                t_edge <= now;
            end
            if (!diff || accept) begin
                cnt_us <= 16'h0000;
            end else if (us_tick) begin
                cnt_us <= cnt_us + 16'd1;
            end
            if (accept) begin
                p.state <= p.raw;
            end
        end
    end

    // ==================================================
    // timestamp from the raw edge that started the transition; with a zero delay, from the start of the previous one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            p.ts <= 64'h0;
            p.ts_evt <= 1'b0;
        end else if (ce) begin
            p.ts_evt <= do_ts;
            if (do_ts) begin
                p.ts <= t_edge;
            end
        end
    end

    // ==================================================
    // chatter window
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ms_cnt <= 10'h000;
            tr_cnt <= 7'h00;
            p.chat_evt <= 1'b0;
        end else if (ce) begin
            if (!p.chat_en) begin
                ms_cnt <= 10'h000;
                tr_cnt <= 7'h00;
                p.chat_evt <= 1'b0;
            end else begin
                p.chat_evt <= chat_hit;
                if (win_end) begin
                    ms_cnt <= 10'h000;
                end else if (ms_tick) begin
                    ms_cnt <= ms_cnt + 10'd1;
                end
                if (chat_hit) begin
                    tr_cnt <= 7'h00;
                end else if (accept) begin
                    tr_cnt <= tr_base + 7'd1;
                end else begin
                    tr_cnt <= tr_base;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> test/ipc_field_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==================================================
// field sensors: steady levels, moved on the clock edge
module ipc_field_model (
    // timing
    input wire logic aclk,
    // sensor lines
    output logic [15:0] pins
);
    initial pins = 16'h0000;
    // a sensor always drives its line, so no released state exists
    task automatic set_pt(input int i, input logic v);
        @(posedge aclk);
        pins[i] <= v;
    endtask
endmodule
`default_nettype wire

// >>> test/ipc_top_props.sv
`timescale 1ns/10ps
`default_nettype none
// ==================================================
// port relations of the register bus and interrupt
module ipc_top_props
    import ipc_pkg::*;
(
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    // interrupt
    input wire logic irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("bvalid dropped early");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before rready");
    a_read_latency: assert property (ce && s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    a_write_latency: assert property (ce && s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer not two edges after beats");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken while read pending");
    a_write_refused: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("beat taken while response pending");
    a_unmapped_zero: assert property (s_axi_rvalid
        && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read with nonzero data");
    a_irq_held: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
        else $error("interrupt dropped without a register write");
    c_irq: cover property ($rose(irq));
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
    c_bstall: cover property (s_axi_bvalid && !s_axi_bready);
endmodule
`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import ipc_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ce = 1'b1;
    logic [63:0] time_now = 64'h0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [15:0] pins;
    int n_fail = 0, checks = 0, cyc = 0, seed = 74761;
    ipc_field_model u_fld (.aclk(aclk), .pins(pins));
    ipc_top #(.NP(16)) u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .pin_in(pins), .time_now(time_now), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
    // ==================================================
    // clock, time base, timeout
    always #5 aclk = ~aclk;
    always @(posedge aclk) begin
        time_now <= time_now + 64'd10;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            print_verdict();
        end
    end
    // ==================================================
    // shared tasks
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    function automatic logic [11:0] pa(input int i, input logic [4:0] o);
        return A_PT_BASE + 12'(i << PT_STRIDE_LOG2) + {7'h0, o};
    endfunction
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic ha, hw, hb, bv;
        hb = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'($random(seed));
        while (!hb) begin
            @(negedge aclk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            bv = bvalid;
            hb = bvalid && bready;
            if (hb) chk(32'(bresp), 32'(RESP_OKAY));
            @(posedge aclk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            if (bv) bready <= !hb;
        end
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        logic ha, hr, rv;
        hr = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'($random(seed));
        while (!hr) begin
            @(negedge aclk);
            ha = arvalid && arready;
            rv = rvalid;
            hr = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ha) arvalid <= 1'b0;
            if (rv) rready <= !hr;
        end
    endtask
    task automatic wait_c(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // ==================================================
    // main sequence; exp_st models the filtered state
    initial begin
        logic [31:0] d, m, ts_a;
        logic [1:0] r;
        logic [63:0] t0;
        int exp_st;
        exp_st = 0;
        wait_c(16);
        aresetn <= 1'b1;
        rd(pa(0, O_DLY_ON), d, r);
        chk(d, 32'h0);
        rd(pa(0, O_CFG), d, r);
        chk(d, 32'h0001_0200);
        rd(12'h100, d, r);
        chk({d[31:2], r}, {30'h0, RESP_SLVERR});
        m = $random(seed);
        wr(A_IRQ_MASK, m);
        rd(A_IRQ_MASK, d, r);
        chk(d, m);
        wr(A_IRQ_MASK, 32'h0);
        wr(pa(0, O_DLY_OFF), 32'hc350);
        rd(pa(0, O_DLY_OFF), d, r);
        chk(d, 32'hc350);
        wr(pa(1, O_CFG), 32'h03e8_7f08);
        rd(pa(1, O_CFG), d, r);
        chk(d, 32'h03e8_7f08);
        $display("test registers done");
        wr(pa(0, O_DLY_ON), 32'h2);
        wr(pa(0, O_DLY_OFF), 32'h3);
        wr(pa(0, O_CFG), 32'h0001_0201);
        u_fld.set_pt(0, 1'b1);
        wait_c(60);
        u_fld.set_pt(0, 1'b0);
        wait_c(400);
        rd(A_STATE, d, r);
        chk(d & 32'hffff, 32'(exp_st));
        rd(A_IRQ_STAT, d, r);
        chk(d, 32'h0);
        u_fld.set_pt(0, 1'b1);
        t0 = time_now;
        wait_c(60);
        rd(A_STATE, d, r);
        chk(d & 32'h1, 32'(exp_st));
        // ce low freezes the filter count, so the point stays off
        ce <= 1'b0;
        wait_c(400);
        ce <= 1'b1;
        rd(A_STATE, d, r);
        chk(d & 32'h1, 32'(exp_st));
        wait_c(300);
        exp_st = 1;
        rd(A_STATE, d, r);
        chk(d & 32'h1, 32'(exp_st));
        rd(A_IRQ_STAT, d, r);
        chk(d, 32'h0001_0000);
        rd(pa(0, O_TS_LO), ts_a, r);
        chk(32'(ts_a - t0[31:0] <= 32'd10000), 32'h1);
        wr(A_IRQ_MASK, 32'h0001_0000);
        @(negedge aclk);
        chk(32'(irq), 32'h1);
        $display("test on filter done");
        wr(pa(0, O_CFG), 32'h0001_0206);
        u_fld.set_pt(0, 1'b0);
        wait_c(60);
        rd(A_STATE, d, r);
        chk(d & 32'h1, 32'(exp_st));
        wait_c(400);
        exp_st = 0;
        rd(A_STATE, d, r);
        chk(d & 32'h1, 32'(exp_st));
        rd(pa(0, O_TS_LO), d, r);
        chk(d, ts_a);
        wr(A_IRQ_STAT, 32'h0001_0000);
        @(negedge aclk);
        chk(32'(irq), 32'h0);
        u_fld.set_pt(0, 1'b1);
        wait_c(350);
        rd(A_IRQ_STAT, d, r);
        chk(d, 32'h0);
        u_fld.set_pt(0, 1'b0);
        t0 = time_now;
        wait_c(450);
        rd(A_IRQ_STAT, d, r);
        chk(d, 32'h0001_0000);
        rd(pa(0, O_TS_LO), d, r);
        chk(32'(d - t0[31:0] <= 32'd10000), 32'h1);
        $display("test capture and latch done");
        wr(A_IRQ_MASK, 32'h0000_0002);
        wr(pa(1, O_CFG), 32'h0001_0308);
        for (int k = 0; k < 3; k++) begin
            u_fld.set_pt(1, k[0] == 1'b0);
            wait_c(20);
            rd(A_IRQ_STAT, d, r);
            chk(d & 32'h2, (k == 2) ? 32'h2 : 32'h0);
        end
        wr(A_IRQ_STAT, 32'h0000_0002);
        wr(pa(1, O_CFG), 32'h0001_0300);
        for (int k = 0; k < 3; k++) begin
            u_fld.set_pt(1, k[0] == 1'b1);
            wait_c(20);
        end
        rd(A_IRQ_STAT, d, r);
        chk(d & 32'h2, 32'h0);
        $display("test chatter done");
        print_verdict();
    end
endmodule
bind ipc_top ipc_top_props u_props (.aclk(aclk), .aresetn(aresetn),
    .ce(ce), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .irq(irq));
`default_nettype wire
